// >>> hw/tsa_consts.vh
`ifndef TSA_CONSTS_VH
`define TSA_CONSTS_VH
// APB register byte offsets
`define TSA_A_CONFIG 8'h00
`define TSA_A_TEMP 8'h04
`define TSA_A_STATUS 8'h08
`define TSA_A_IRQ_STAT 8'h0C
`define TSA_A_IRQ_MASK 8'h10
// Serial register addresses (command bits 5:3)
`define TSA_S_STATUS 3'h0
`define TSA_S_CONFIG 3'h1
`define TSA_S_TEMP 3'h2
// Command byte fields
`define TSA_CMD_RD 6
`define TSA_CMD_AHI 5
`define TSA_CMD_ALO 3
// Configuration fields
`define TSA_CF_FQ_HI 1
`define TSA_CF_FQ_LO 0
`define TSA_CF_CRIT_POL 2
`define TSA_CF_LIM_POL 3
`define TSA_CF_INT_MODE 4
`define TSA_CF_OP_HI 6
`define TSA_CF_OP_LO 5
`define TSA_CF_RES16 7
`define TSA_CONFIG_RST 8'h00
// Operating modes
`define TSA_OP_CONT 2'h0
`define TSA_OP_ONESHOT 2'h1
`define TSA_OP_SPS1 2'h2
`define TSA_OP_SHDN 2'h3
// Interrupt event bits
`define TSA_EV_CFGWR 0
`define TSA_EV_IFRST 1
`define TSA_EV_CRIT 2
`define TSA_EV_LIM 3
`define TSA_EV_CONV 4
`define TSA_NEV 5
// Serial framing counts
`define TSA_CMD_BITS 5'h08
`define TSA_WR_BITS 5'h10
`define TSA_ONES_RST 6'h20
`endif

// >>> hw/tsa_alerts.v
// What this block does
// - Serial output bit changes after each falling shift clock edge of a read.
// - Serial input sampled on each rising shift clock edge while selected.
// - Serial lines act only while select is low; ignored while high.
// - Serial transfers are timed solely by the host shift clock edges.
// - Limit alert resets to comparator mode, active low.
// - Critical alert resets to active low.
// - Both alerts are open drain: pull low or release only.
// - Results 13-bit by default, 16-bit when resolution bit set.
// - Mode field switches continuous operation and full power-down.
// - Mode bit picks comparator or interrupt behaviour for both alerts.
// - Polarity bits set active level of each alert output.
// - Fault-count field sets faults needed before an alert fires.
// - Mode field enables one-shot and once-per-second sampling.
// - Config bits 6:5 are the mode field; 11 means shutdown.
// - Config bits 1:0 set how many consecutive out-of-limit conversions an alert needs.
// - In interrupt mode any serial register read releases both alerts.
// - Thirty-two consecutive ones on data input reset the serial port.
`timescale 1ns/1ps
`default_nettype none
`include "tsa_consts.vh"
module tsa_alerts (
  // Clock and reset
  input wire MCLK,
  input wire RESET,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  output reg IRQ,
  // Serial port pins
  input wire SCLK,
  input wire CS_N,
  input wire DIN,
  output reg DOUT_O,
  output reg DOUT_OE,
  // Open-drain alert pins
  output reg CRITICAL_ALERT_OUT_O,
  output reg CRITICAL_ALERT_OUT_OE,
  output reg LIMIT_ALERT_O,
  output reg LIMIT_ALERT_OE,
  // Converter side
  input wire [15:0] TEMP_VALUE,
  input wire TEMP_VALID,
  input wire OVER_CRIT,
  input wire OUT_OF_LIMIT,
  output reg CONV_RUN,
  output reg ONE_SHOT_GO,
  output reg ONCE_PER_SECOND_MODE,
  output reg RES16
);

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
reg [2:0] sclk_sync_reg;
reg [1:0] cs_sync_reg;
reg [1:0] din_sync_reg;
wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
wire selected = ~cs_sync_reg[1];
wire din_s = din_sync_reg[1];

always @(posedge MCLK)
begin
  if (RESET)
  begin
    // Idle-high start, so no false edge follows reset
    sclk_sync_reg <= 3'h7;
    cs_sync_reg <= 2'h3;
    din_sync_reg <= 2'h0;
  end
  else
  begin
    sclk_sync_reg <= {sclk_sync_reg[1:0], SCLK};
    cs_sync_reg <= {cs_sync_reg[0], CS_N};
    din_sync_reg <= {din_sync_reg[0], DIN};
  end
end

// ----------------------------------------
// Serial engine
// ----------------------------------------
reg [7:0] config_reg;
reg [15:0] temp_reg;
reg [4:0] bit_cnt_reg;
reg [5:0] ones_cnt_reg;
reg [7:0] cmd_reg;
reg [15:0] rx_reg;
reg [15:0] tx_reg;
reg reading_reg;
reg spi_cfg_wr;
reg spi_rd_pulse;
reg if_reset;
reg [7:0] spi_cfg_val;
wire [1:0] crit_lim_act;
wire [7:0] status_byte = {1'b0, crit_lim_act, 5'h00};
wire [15:0] rx_now = {rx_reg[14:0], din_s};
wire [2:0] cmd_addr = rx_now[`TSA_CMD_AHI:`TSA_CMD_ALO];
reg [15:0] rd_word;

always @*
begin
  case (cmd_addr)
    `TSA_S_STATUS: rd_word = {status_byte, 8'h00};
    `TSA_S_CONFIG: rd_word = {config_reg, 8'h00};
    `TSA_S_TEMP: rd_word = temp_reg;
    default: rd_word = 16'h0000;
  endcase
end

always @*
begin
  spi_cfg_wr = 1'b0;
  spi_rd_pulse = 1'b0;
  if_reset = 1'b0;
  spi_cfg_val = rx_now[7:0];
  if (selected && sclk_rise)
  begin
    if (din_s && ones_cnt_reg == `TSA_ONES_RST - 6'h01)
      if_reset = 1'b1;
    else if (bit_cnt_reg == `TSA_CMD_BITS - 5'h01)
      spi_rd_pulse = rx_now[`TSA_CMD_RD];
    else if (bit_cnt_reg == `TSA_WR_BITS - 5'h01 && !reading_reg &&
             cmd_reg[`TSA_CMD_AHI:`TSA_CMD_ALO] == `TSA_S_CONFIG)
      spi_cfg_wr = 1'b1;
  end
end

always @(posedge MCLK)
begin
  if (RESET)
  begin
    bit_cnt_reg <= 5'h00;
    ones_cnt_reg <= 6'h00;
    cmd_reg <= 8'h00;
    rx_reg <= 16'h0000;
    tx_reg <= 16'h0000;
    reading_reg <= 1'b0;
    DOUT_O <= 1'b0;
    DOUT_OE <= 1'b0;
  end
  else if (!selected)
  begin
    // Each selection starts a fresh frame
    bit_cnt_reg <= 5'h00;
    reading_reg <= 1'b0;
    DOUT_OE <= 1'b0;
  end
  else
  begin
    DOUT_OE <= reading_reg;
    if (sclk_rise)
    begin
      // Edges of the host clock are the only transfer timing
      rx_reg <= rx_now;
      ones_cnt_reg <= din_s ? ones_cnt_reg + 6'h01 : 6'h00;
      if (if_reset)
      begin
        bit_cnt_reg <= 5'h00;
        ones_cnt_reg <= 6'h00;
        reading_reg <= 1'b0;
      end
      else
      begin
        if (bit_cnt_reg != 5'h1F)
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        if (bit_cnt_reg == `TSA_CMD_BITS - 5'h01)
        begin
          cmd_reg <= rx_now[7:0];
          reading_reg <= rx_now[`TSA_CMD_RD];
          tx_reg <= rd_word;
        end
      end
    end
    else if (sclk_fall && reading_reg)
    begin
      // Shift on falling edge, stable for host's rising edge
      DOUT_O <= tx_reg[15];
      tx_reg <= {tx_reg[14:0], 1'b0};
    end
  end
end

// ----------------------------------------
// Configuration and mode control
// ----------------------------------------
wire apb_wr = PSEL & PENABLE & PREADY & PWRITE;
wire apb_cfg_wr = apb_wr && PADDR == `TSA_A_CONFIG;
wire cfg_wr = spi_cfg_wr | apb_cfg_wr;
// Serial side wins a same-cycle collision: the host owns the pins
wire [7:0] cfg_new = spi_cfg_wr ? spi_cfg_val : PWDATA[7:0];
wire [1:0] op_mode = config_reg[`TSA_CF_OP_HI:`TSA_CF_OP_LO];
reg oneshot_done_reg;

always @(posedge MCLK)
begin
  if (RESET)
  begin
    config_reg <= `TSA_CONFIG_RST;
    oneshot_done_reg <= 1'b0;
    CONV_RUN <= 1'b0;
    ONE_SHOT_GO <= 1'b0;
    ONCE_PER_SECOND_MODE <= 1'b0;
    RES16 <= 1'b0;
  end
  else
  begin
    if (if_reset)
      config_reg <= `TSA_CONFIG_RST;
    else if (cfg_wr)
      config_reg <= cfg_new;
    ONE_SHOT_GO <= cfg_wr && !if_reset &&
      cfg_new[`TSA_CF_OP_HI:`TSA_CF_OP_LO] == `TSA_OP_ONESHOT;
    if (cfg_wr)
      oneshot_done_reg <= 1'b0;
    else if (op_mode == `TSA_OP_ONESHOT && TEMP_VALID)
      oneshot_done_reg <= 1'b1;
    // Shutdown on 11 stops conversions
    CONV_RUN <= op_mode != `TSA_OP_SHDN &&
      !(op_mode == `TSA_OP_ONESHOT && oneshot_done_reg);
    ONCE_PER_SECOND_MODE <= op_mode == `TSA_OP_SPS1;
    RES16 <= config_reg[`TSA_CF_RES16];
  end
end

always @(posedge MCLK)
begin
  if (RESET)
    temp_reg <= 16'h0000;
  else if (TEMP_VALID)
    // Low three bits are flag slots in 13-bit format
    temp_reg <= config_reg[`TSA_CF_RES16] ? TEMP_VALUE :
      {TEMP_VALUE[15:3], 3'h0};
end

// ----------------------------------------
// Fault queues and alerts
// ----------------------------------------
wire [1:0] fault_in = {OVER_CRIT, OUT_OF_LIMIT};
wire [1:0] fault_q = config_reg[`TSA_CF_FQ_HI:`TSA_CF_FQ_LO];
wire int_mode = config_reg[`TSA_CF_INT_MODE];
wire [1:0] pol_hi = {config_reg[`TSA_CF_CRIT_POL],
  config_reg[`TSA_CF_LIM_POL]};
wire [1:0] alert_set;
reg [1:0] alert_set_reg;
wire [1:0] drive_low = crit_lim_act ^ pol_hi;

genvar g;
generate
  for (g = 0; g < 2; g = g + 1)
  begin : g_alert
    reg [1:0] fcnt_reg;
    reg act_reg;
    wire full = fcnt_reg >= fault_q;
    assign alert_set[g] = TEMP_VALID & fault_in[g] & full;
    assign crit_lim_act[g] = act_reg;
    always @(posedge MCLK)
    begin
      if (RESET)
      begin
        fcnt_reg <= 2'h0;
        act_reg <= 1'b0;
      end
      else
      begin
        // Consecutive faults only; a clean result restarts
        // Count holds once full, so a lasting fault keeps the alert
        if (TEMP_VALID)
          fcnt_reg <= !fault_in[g] ? 2'h0 :
            full ? fcnt_reg : fcnt_reg + 2'h1;
        if (!int_mode)
        begin
          if (TEMP_VALID)
            act_reg <= fault_in[g] & full;
        end
        else if (alert_set[g])
          act_reg <= 1'b1;
        else if (spi_rd_pulse)
          act_reg <= 1'b0;
      end
    end
  end
endgenerate

always @(posedge MCLK)
begin
  if (RESET)
  begin
    alert_set_reg <= 2'h0;
    CRITICAL_ALERT_OUT_O <= 1'b0;
    CRITICAL_ALERT_OUT_OE <= 1'b0;
    LIMIT_ALERT_O <= 1'b0;
    LIMIT_ALERT_OE <= 1'b0;
  end
  else
  begin
    alert_set_reg <= alert_set & ~crit_lim_act;
    // Never drive high; pull-up gives the high level
    CRITICAL_ALERT_OUT_O <= 1'b0;
    LIMIT_ALERT_O <= 1'b0;
    CRITICAL_ALERT_OUT_OE <= drive_low[1];
    LIMIT_ALERT_OE <= drive_low[0];
  end
end

// ----------------------------------------
// Interrupt status and APB slave
// ----------------------------------------
reg [`TSA_NEV-1:0] irq_stat_reg;
reg [`TSA_NEV-1:0] irq_mask_reg;
wire [`TSA_NEV-1:0] ev = {TEMP_VALID, alert_set_reg[0], alert_set_reg[1],
  if_reset, spi_cfg_wr};
wire [`TSA_NEV-1:0] w1c = (apb_wr && PADDR == `TSA_A_IRQ_STAT) ?
  PWDATA[`TSA_NEV-1:0] : {`TSA_NEV{1'b0}};
wire mapped = PADDR == `TSA_A_CONFIG || PADDR == `TSA_A_TEMP ||
  PADDR == `TSA_A_STATUS || PADDR == `TSA_A_IRQ_STAT ||
  PADDR == `TSA_A_IRQ_MASK;
reg [31:0] apb_rd;

always @*
begin
  case (PADDR)
    `TSA_A_CONFIG: apb_rd = {24'h000000, config_reg};
    `TSA_A_TEMP: apb_rd = {16'h0000, temp_reg};
    `TSA_A_STATUS: apb_rd = {24'h000000, selected, 3'h0, CONV_RUN,
      oneshot_done_reg, crit_lim_act};
    `TSA_A_IRQ_STAT: apb_rd = {27'h0000000, irq_stat_reg};
    `TSA_A_IRQ_MASK: apb_rd = {27'h0000000, irq_mask_reg};
    default: apb_rd = 32'h00000000;
  endcase
end

always @(posedge MCLK)
begin
  if (RESET)
  begin
    PRDATA <= 32'h00000000;
    PREADY <= 1'b0;
    PSLVERR <= 1'b0;
    IRQ <= 1'b0;
    irq_stat_reg <= {`TSA_NEV{1'b0}};
    irq_mask_reg <= {`TSA_NEV{1'b0}};
  end
  else
  begin
    // One wait state: ready rises on the second access cycle
    PREADY <= PSEL & PENABLE & ~PREADY;
    PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
    if (PSEL && PENABLE && !PREADY && !PWRITE)
      PRDATA <= apb_rd;
    // A new event beats a same-cycle clear
    irq_stat_reg <= (irq_stat_reg & ~w1c) | ev;
    if (apb_wr && PADDR == `TSA_A_IRQ_MASK)
      irq_mask_reg <= PWDATA[`TSA_NEV-1:0];
    IRQ <= |(irq_stat_reg & irq_mask_reg);
  end
end

endmodule // tsa_alerts
`default_nettype wire

// >>> sim/tsa_alerts_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsa_consts.vh"
module tsa_alerts_checker (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // Bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  // Serial and alerts
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DOUT_O,
  input wire logic DOUT_OE,
  input wire logic CRITICAL_ALERT_OUT_O,
  input wire logic CRITICAL_ALERT_OUT_OE,
  input wire logic LIMIT_ALERT_O,
  input wire logic LIMIT_ALERT_OE,
  // Converter control
  input wire logic CONV_RUN,
  input wire logic ONE_SHOT_GO,
  input wire logic ONCE_PER_SECOND_MODE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  // ----
  // Checks
  // ----
  wire cw = PSEL && PENABLE && PREADY && PWRITE && PADDR == `TSA_A_CONFIG;
  a_od_pins: assert property (
    !CRITICAL_ALERT_OUT_O && !LIMIT_ALERT_O)
    else $error("alert pin driven high");
  a_rst_alerts: assert property (
    $fell(RESET) |-> !CRITICAL_ALERT_OUT_OE && !LIMIT_ALERT_OE)
    else $error("alert active after reset");
  a_dout_idle: assert property (
    CS_N [*4] |-> !DOUT_OE)
    else $error("data out driven while idle");
  // Sync lag puts the change about three cycles after the fall
  a_dout_fall: assert property (
    DOUT_OE && $past(DOUT_OE) && $changed(DOUT_O) |-> !$past(SCLK, 2))
    else $error("data out moved off falling edge");
  a_apb_ready: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("bus access not answered");
  a_mode_shdn: assert property (
    cw && PWDATA[6:5] == 2'h3 |-> ##[1:2] !CONV_RUN)
    else $error("shutdown not entered");
  a_mode_sps: assert property (
    cw && PWDATA[6:5] == 2'h2 |-> ##[1:2] ONCE_PER_SECOND_MODE)
    else $error("slow mode not entered");
  a_mode_once: assert property (
    cw && PWDATA[6:5] == 2'h1 |-> ##[1:2] ONE_SHOT_GO)
    else $error("single conversion not started");
endmodule  // tsa_alerts_checker
bind tsa_alerts tsa_alerts_checker chk_i (.MCLK, .RESET, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PREADY, .SCLK, .CS_N, .DOUT_O, .DOUT_OE,
  .CRITICAL_ALERT_OUT_O, .CRITICAL_ALERT_OUT_OE, .LIMIT_ALERT_O,
  .LIMIT_ALERT_OE, .CONV_RUN, .ONE_SHOT_GO, .ONCE_PER_SECOND_MODE);
`default_nettype wire

// >>> sim/tsa_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsa_host_model (
  // Serial pins
  output logic SCLK,
  output logic CS_N,
  output logic DIN,
  input wire logic MISO
);
  initial
  begin
    SCLK = 1'h1;
    CS_N = 1'h1;
    DIN = 1'h0;
  end
  // Clock idles high and stands still between frames
  task automatic xfer(input logic [31:0] tx, input int n,
    output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    CS_N <= 1'h0;
    #107;
    for (i = n - 1; i >= 0; i--)
    begin
      SCLK = 1'h0;
      DIN = tx[i];
      #100;
      SCLK = 1'h1;
      rx = {rx[14:0], MISO};
      #100;
    end
    CS_N = 1'h1;
    DIN = ~DIN;
    #200;
  endtask
endmodule  // tsa_host_model
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsa_consts.vh"
module tb_top;
  logic MCLK = 1'h0;
  logic RESET = 1'h1;
  logic PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, e, junk = 1'h0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, q;
  logic [15:0] TEMP_VALUE = 16'h0000, rx;
  logic TEMP_VALID = 1'h0, OVER_CRIT = 1'h0, OUT_OF_LIMIT = 1'h0;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, IRQ, SCLK, CS_N, DIN, DOUT_O, DOUT_OE, RES16;
  wire CRITICAL_ALERT_OUT_O, CRITICAL_ALERT_OUT_OE, LIMIT_ALERT_O;
  wire LIMIT_ALERT_OE, CONV_RUN, ONE_SHOT_GO, ONCE_PER_SECOND_MODE;
  int miscompares = 0, samples_checked = 0;
  // Released data line toggles so a stale bit cannot pass
  wire miso = DOUT_OE ? DOUT_O : junk;
  wire crit_pin = CRITICAL_ALERT_OUT_OE ? CRITICAL_ALERT_OUT_O : 1'h1;
  wire lim_pin = LIMIT_ALERT_OE ? LIMIT_ALERT_O : 1'h1;
  always #12.5 MCLK = ~MCLK;
  always @(posedge MCLK) junk <= ~junk;
  tsa_alerts uut (.MCLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .IRQ, .SCLK, .CS_N, .DIN, .DOUT_O, .DOUT_OE,
    .CRITICAL_ALERT_OUT_O, .CRITICAL_ALERT_OUT_OE, .LIMIT_ALERT_O,
    .LIMIT_ALERT_OE, .TEMP_VALUE, .TEMP_VALID, .OVER_CRIT, .OUT_OF_LIMIT,
    .CONV_RUN, .ONE_SHOT_GO, .ONCE_PER_SECOND_MODE, .RES16);
  tsa_host_model h (.SCLK, .CS_N, .DIN, .MISO(miso));
  // ----
  // Tasks
  // ----
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK) PENABLE <= 1'h1;
    k = 0;
    do
    begin
      @(posedge MCLK);
      k++;
    end
    while (PREADY !== 1'h1 && k < 20);
    if (PREADY !== 1'h1)
    begin
      miscompares++;
      end_of_test;
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge MCLK);
  endtask
  task ser(input logic [31:0] tx, input int n);
    h.xfer(tx, n, rx);
    @(posedge MCLK);
  endtask
  task conv(input logic [15:0] v, input logic oc, input logic ol);
    TEMP_VALUE <= v;
    OVER_CRIT <= oc;
    OUT_OF_LIMIT <= ol;
    TEMP_VALID <= 1'h1;
    @(posedge MCLK) TEMP_VALID <= 1'h0;
    cyc(4);
  endtask
  // ----
  // Scenarios
  // ----
  task t_reset;
    chk({crit_pin, lim_pin}, 2'h3);
    apb(1'h0, `TSA_A_CONFIG, 32'h0);
    chk(q, 32'h0);
    chk(RES16, 1'h0);
    apb(1'h0, 8'h14, 32'h0);
    chk(e, 1'h1);
    chk(q, 32'h0);
  endtask
  task t_modes;
    int m;
    for (m = 0; m < 4; m++)
    begin
      apb(1'h1, `TSA_A_CONFIG, {24'h0, 1'h1, m[1:0], 5'h00});
      cyc(2);
      chk(RES16, 1'h1);
      chk(ONCE_PER_SECOND_MODE, m == 2);
      chk(CONV_RUN, m != 3);
      if (m == 1)
      begin
        conv(16'h0000, 1'h0, 1'h0);
        chk(CONV_RUN, 1'h0);
      end
    end
  endtask
  task t_temp;
    apb(1'h1, `TSA_A_CONFIG, 32'h80);
    conv(16'h1235, 1'h0, 1'h0);
    ser(32'h500000, 24);
    chk(rx, 16'h1235);
    apb(1'h1, `TSA_A_CONFIG, 32'h0);
    conv(16'h1235, 1'h0, 1'h0);
    apb(1'h0, `TSA_A_TEMP, 32'h0);
    chk(q, 32'h1230);
  endtask
  task t_serial;
    ser(32'h0883, 16);
    apb(1'h0, `TSA_A_CONFIG, 32'h0);
    chk(q, 32'h83);
    ser(32'h480000, 24);
    chk(rx, 16'h8300);
  endtask
  task t_ifrst;
    apb(1'h1, `TSA_A_IRQ_STAT, 32'h1F);
    ser(32'hFFFFFFFF, 32);
    apb(1'h0, `TSA_A_CONFIG, 32'h0);
    chk(q, 32'h0);
    apb(1'h0, `TSA_A_IRQ_STAT, 32'h0);
    chk({q[1], IRQ}, 2'h2);
    apb(1'h1, `TSA_A_IRQ_MASK, 32'h02);
    cyc(2);
    chk(IRQ, 1'h1);
    apb(1'h1, `TSA_A_IRQ_STAT, 32'h02);
    cyc(2);
    chk(IRQ, 1'h0);
    apb(1'h1, `TSA_A_IRQ_MASK, 32'h0);
  endtask
  task t_alert;
    apb(1'h1, `TSA_A_CONFIG, 32'h01);
    conv(16'h0000, 1'h1, 1'h1);
    chk({crit_pin, lim_pin}, 2'h3);
    conv(16'h0000, 1'h1, 1'h1);
    chk({crit_pin, lim_pin}, 2'h0);
    conv(16'h0000, 1'h1, 1'h1);
    chk({crit_pin, lim_pin}, 2'h0);
    conv(16'h0000, 1'h0, 1'h0);
    chk({crit_pin, lim_pin}, 2'h3);
    apb(1'h1, `TSA_A_CONFIG, 32'h10);
    conv(16'h0000, 1'h0, 1'h1);
    conv(16'h0000, 1'h0, 1'h0);
    chk(lim_pin, 1'h0);
    ser(32'h400000, 24);
    chk(rx, 16'h2000);
    chk(lim_pin, 1'h1);
    apb(1'h1, `TSA_A_CONFIG, 32'h0C);
    conv(16'h0000, 1'h0, 1'h0);
    chk({crit_pin, lim_pin}, 2'h0);
    conv(16'h0000, 1'h1, 1'h1);
    chk({crit_pin, lim_pin}, 2'h3);
  endtask
  task t_rerst;
    conv(16'h0000, 1'h0, 1'h0);
    chk({crit_pin, lim_pin}, 2'h0);
    RESET <= 1'h1;
    cyc(2);
    RESET <= 1'h0;
    cyc(4);
    chk({crit_pin, lim_pin}, 2'h3);
    apb(1'h0, `TSA_A_CONFIG, 32'h0);
    chk(q, 32'h0);
  endtask
  initial
  begin
    cyc(20);
    RESET <= 1'h0;
    cyc(4);
    t_reset;
    t_modes;
    t_temp;
    t_serial;
    t_ifrst;
    t_alert;
    t_rerst;
    end_of_test;
  end
endmodule  // tb_top
`default_nettype wire
